/* verilog/scb_buffer.sv */
// Shared channel data buffer: packs load read data, holds per-channel queues
// in one linked-list pool, and drains entries unchanged for stores.
// Assumes read beats arrive in order per channel after a load descriptor.
//
// Notes on behaviour
// [R1] One shared pool, first-come first-served grants
// [R2] Per-channel queues; total never exceeds depth
// [R3] Entry width equals data bus; depth parameterised
// [R4] Rotate source bytes onto destination lanes
// [R5] Shift on entry; drain unchanged on stores
// [R6] Destination address and settings set placement
// [R7] Incrementing destination packs entries densely
// [R8] One read per load, one write per store
// [R9] Partial first and last entries accounted
// [R10] Pool full stalls read data acceptance
// [R11] Byte order kept; drained entries freed
`timescale 1ns/100ps
`default_nettype none
`include "scb_params.svh"
module scb_buffer #(
  parameter int DATA_W = `SCB_DATA_W,
  parameter int DEPTH = `SCB_POOL_DEPTH,
  parameter int IN_DEPTH = `SCB_INFIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  // Load descriptor, one per load instruction
  input wire logic ld_start,
  input wire scb_pkg::scb_chan_t ld_chan,
  input wire logic [$clog2(DATA_W/8)-1:0] ld_src_off,
  input wire logic [$clog2(DATA_W/8):0] ld_src_size,
  input wire logic ld_src_inc,
  input wire logic [$clog2(DATA_W/8)-1:0] ld_dst_off,
  input wire logic ld_dst_inc,
  input wire logic ld_flush,
  // AXI read data channel
  input wire logic rvalid,
  input wire logic [DATA_W-1:0] rdata,
  input wire scb_pkg::scb_chan_t rid,
  input wire logic rlast,
  output logic rready,
  // Store drain request, one entry per request
  input wire logic st_req,
  input wire scb_pkg::scb_chan_t st_chan,
  output logic st_taken,
  // Write data toward the AXI write channel
  output logic wvalid,
  output logic [DATA_W-1:0] wdata,
  output logic [DATA_W/8-1:0] wstrb,
  output scb_pkg::scb_chan_t wchan,
  input wire logic wready,
  // Pool occupancy
  output logic [$clog2(DEPTH+1)-1:0] used
);
  import scb_pkg::*;
  localparam int L = DATA_W / 8;
  localparam int LW = $clog2(L);
  localparam int CH = `SCB_CHANNELS;
  localparam int PW = $clog2(DEPTH);
  localparam int EW = `SCB_CHAN_W + L + DATA_W;
  localparam int FCW = $clog2(IN_DEPTH+1);

  // Rotate a word left by r byte lanes
  function automatic logic [DATA_W-1:0] rotl(input logic [DATA_W-1:0] v, input logic [LW-1:0] r);
    logic [DATA_W-1:0] o;
    logic [LW-1:0] k;
    o = '0;
    for (int i = 0; i < L; i++) begin
      k = LW'(i) - r;
      o[i*8 +: 8] = v[k*8 +: 8];
    end
    return o;
  endfunction : rotl

  // Lowest free pool slot
  function automatic logic [PW-1:0] first_free(input logic [DEPTH-1:0] busy);
    logic [PW-1:0] idx;
    idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        idx = PW'(i);
      end
    end
    return idx;
  endfunction : first_free

  // Per-channel load settings and packing state
  logic [LW-1:0] src_ptr_reg [CH]; // Next source lane
  logic [LW:0] src_size_reg [CH]; // Beat size in bytes
  logic src_inc_reg [CH]; // Source increments
  logic [LW-1:0] dst_ptr_reg [CH]; // Next destination lane
  logic dst_inc_reg [CH]; // Destination increments
  logic flush_reg [CH]; // Push partial at load end
  logic [DATA_W-1:0] pack_data_reg [CH]; // Partial entry bytes
  logic [L-1:0] pack_strb_reg [CH]; // Partial entry lanes
  logic flush_pend_reg; // Partial entry awaiting push
  scb_chan_t flush_chan_reg; // Channel of that entry
  logic rready_reg; // Registered read ready

  // Shared pool
  logic [DATA_W-1:0] pool_data [DEPTH]; // Entry bytes
  logic [L-1:0] pool_strb [DEPTH]; // Entry lanes
  logic [PW-1:0] pool_next [DEPTH]; // Link to next entry
  logic [DEPTH-1:0] busy_reg; // Slot in use
  logic [PW-1:0] head_reg [CH]; // Oldest entry
  logic [PW-1:0] tail_reg [CH]; // Newest entry
  logic [PW:0] cnt_reg [CH]; // Entries held
  logic [$clog2(DEPTH+1)-1:0] used_reg; // Total held

  // Write output stage
  logic wvalid_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [L-1:0] wstrb_reg;
  scb_chan_t wchan_reg;
  logic st_taken_reg;

  scb_entry_if #(.W(EW)) pk_if ();
  scb_entry_if #(.W(EW)) pl_if ();
  logic [FCW-1:0] fifo_cnt; // Input FIFO occupancy

  // Beat packing, combinational
  logic beat; // Beat accepted
  logic [LW-1:0] s_lane; // Source start lane
  logic [LW:0] n_bytes; // Useful bytes this beat
  logic [LW-1:0] d_lane; // Destination start lane
  logic [LW:0] end_lane; // Destination end lane
  logic [DATA_W-1:0] rot; // Realigned beat
  logic [L-1:0] take; // Lanes filled by beat
  logic [L-1:0] hi; // Lanes at or above start
  logic done; // Entry completes
  logic [DATA_W-1:0] out_data; // Completed entry bytes
  logic [L-1:0] out_strb; // Completed entry lanes
  logic [DATA_W-1:0] new_data; // Partial after beat
  logic [L-1:0] new_strb; // Partial lanes after beat
  logic [LW-1:0] rel; // Lane relative to start

  assign beat = rvalid && rready_reg; // [R10]
  always_comb begin
    s_lane = src_ptr_reg[rid];
    n_bytes = src_size_reg[rid] - ((LW+1)'(s_lane) & (src_size_reg[rid] - 1'b1)); // [R9]
    d_lane = dst_ptr_reg[rid];
    end_lane = (LW+1)'(d_lane) + n_bytes;
    rot = rotl(rdata, d_lane - s_lane); // [R4]
    take = '0;
    hi = '0;
    for (int i = 0; i < L; i++) begin
      rel = LW'(i) - d_lane;
      take[i] = ((LW+1)'(rel) < n_bytes);
      hi[i] = (LW'(i) >= d_lane);
    end
    new_data = pack_data_reg[rid];
    out_data = pack_data_reg[rid];
    for (int i = 0; i < L; i++) begin
      if (take[i]) begin
        new_data[i*8 +: 8] = rot[i*8 +: 8];
      end
      if (take[i] && hi[i]) begin
        out_data[i*8 +: 8] = rot[i*8 +: 8];
      end
    end
    if (!dst_inc_reg[rid]) begin
      // Fixed destination: each beat is its own entry
      done = 1'b1;
      out_data = rot;
      out_strb = take;
      new_strb = '0;
    end else if (end_lane >= (LW+1)'(L)) begin
      // Entry fills; wrapped bytes start the next one
      done = 1'b1;
      out_strb = pack_strb_reg[rid] | (take & hi);
      new_strb = take & ~hi; // [R7]
    end else begin
      done = 1'b0;
      out_strb = pack_strb_reg[rid];
      new_strb = pack_strb_reg[rid] | take; // [R7]
    end
  end

  // Packer output toward the input FIFO
  always_comb begin
    pk_if.valid = 1'b0;
    pk_if.data = '0;
    if (flush_pend_reg) begin
      pk_if.valid = 1'b1;
      pk_if.data = {flush_chan_reg, pack_strb_reg[flush_chan_reg], pack_data_reg[flush_chan_reg]}; // [R9]
    end else if (beat && done) begin
      pk_if.valid = 1'b1;
      pk_if.data = {rid, out_strb, out_data}; // [R5]
    end
  end

  scb_fifo #(.W(EW), .DEPTH(IN_DEPTH)) u_in_fifo (
    .clk(clk),
    .rst(rst),
    .in_if(pk_if.cons),
    .out_if(pl_if.prod),
    .count(fifo_cnt)
  );

  // Read ready: room for two more pushes and no flush outstanding
  always_ff @(posedge clk) begin
    if (rst) begin
      rready_reg <= 1'b0;
    end else begin
      rready_reg <= (fifo_cnt < FCW'(IN_DEPTH-1)) && !flush_pend_reg
        && !(beat && rlast && flush_reg[rid] && (new_strb != '0)); // [R10]
    end
  end

  // Flush of a partial last entry after the final beat
  always_ff @(posedge clk) begin
    if (rst) begin
      flush_pend_reg <= 1'b0;
      flush_chan_reg <= '0;
    end else if (flush_pend_reg) begin
      if (pk_if.ready) begin
        flush_pend_reg <= 1'b0;
      end
    end else if (beat && rlast && flush_reg[rid] && (new_strb != '0)) begin
      flush_pend_reg <= 1'b1; // [R9]
      flush_chan_reg <= rid;
    end
  end

  // Per-channel settings and packing state
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < CH; c++) begin
        src_ptr_reg[c] <= '0;
        src_size_reg[c] <= (LW+1)'(L);
        src_inc_reg[c] <= 1'b1;
        dst_ptr_reg[c] <= '0;
        dst_inc_reg[c] <= 1'b1;
        flush_reg[c] <= 1'b0;
        pack_data_reg[c] <= '0;
        pack_strb_reg[c] <= '0;
      end
    end else begin
      if (flush_pend_reg && pk_if.ready) begin
        pack_strb_reg[flush_chan_reg] <= '0;
      end
      if (beat) begin
        src_ptr_reg[rid] <= src_inc_reg[rid] ? end_lane[LW-1:0] + (s_lane - d_lane) : s_lane;
        if (dst_inc_reg[rid]) begin
          dst_ptr_reg[rid] <= end_lane[LW-1:0]; // [R6]
        end
        pack_data_reg[rid] <= new_data;
        pack_strb_reg[rid] <= new_strb;
      end
      if (ld_start) begin
        src_ptr_reg[ld_chan] <= ld_src_off;
        src_size_reg[ld_chan] <= ld_src_size;
        src_inc_reg[ld_chan] <= ld_src_inc;
        dst_inc_reg[ld_chan] <= ld_dst_inc;
        flush_reg[ld_chan] <= ld_flush;
        // A flush that empties this channel now counts as empty
        if (pack_strb_reg[ld_chan] == '0 || (flush_pend_reg && pk_if.ready && flush_chan_reg == ld_chan)) begin
          dst_ptr_reg[ld_chan] <= ld_dst_off; // [R6]
        end
      end
    end
  end

  // Pool write and store pop decisions
  logic alloc; // Entry enters pool
  logic [PW-1:0] alloc_idx; // Slot it takes
  scb_chan_t in_chan; // Owner of that entry
  logic pop; // Store takes an entry
  logic [PW-1:0] pop_idx; // Slot it frees
  assign alloc_idx = first_free(busy_reg); // [R1]
  assign pl_if.ready = !(&busy_reg); // [R2]
  assign alloc = pl_if.valid && pl_if.ready; // [R1]
  assign in_chan = pl_if.data[EW-1 -: `SCB_CHAN_W];
  assign pop = st_req && (cnt_reg[st_chan] != '0) && (!wvalid_reg || wready); // [R8]
  assign pop_idx = head_reg[st_chan];

  // Entry storage and links
  always_ff @(posedge clk) begin
    if (alloc) begin
      pool_data[alloc_idx] <= pl_if.data[DATA_W-1:0]; // [R3]
      pool_strb[alloc_idx] <= pl_if.data[DATA_W +: L];
      if (cnt_reg[in_chan] != '0) begin
        pool_next[tail_reg[in_chan]] <= alloc_idx; // [R11]
      end
    end
  end

  // Slot ownership, queue heads, tails and counts
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= '0;
      used_reg <= '0;
      for (int c = 0; c < CH; c++) begin
        head_reg[c] <= '0;
        tail_reg[c] <= '0;
        cnt_reg[c] <= '0;
      end
    end else begin
      if (pop) begin
        busy_reg[pop_idx] <= 1'b0; // [R11]
        head_reg[st_chan] <= pool_next[pop_idx];
      end
      if (alloc) begin
        busy_reg[alloc_idx] <= 1'b1;
        tail_reg[in_chan] <= alloc_idx;
        if (cnt_reg[in_chan] == '0 || (pop && st_chan == in_chan && cnt_reg[in_chan] == (PW+1)'(1))) begin
          head_reg[in_chan] <= alloc_idx;
        end
      end
      for (int c = 0; c < CH; c++) begin
        cnt_reg[c] <= cnt_reg[c] + (PW+1)'(alloc && in_chan == scb_chan_t'(c))
          - (PW+1)'(pop && st_chan == scb_chan_t'(c)); // [R2]
      end
      used_reg <= used_reg + ($clog2(DEPTH+1))'(alloc) - ($clog2(DEPTH+1))'(pop);
    end
  end

  // Write output stage: entries leave unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      wvalid_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      wchan_reg <= '0;
      st_taken_reg <= 1'b0;
    end else begin
      st_taken_reg <= pop;
      if (pop) begin
        wvalid_reg <= 1'b1;
        wdata_reg <= pool_data[pop_idx]; // [R5]
        wstrb_reg <= pool_strb[pop_idx];
        wchan_reg <= st_chan;
      end else if (wready) begin
        wvalid_reg <= 1'b0;
      end
    end
  end

  assign rready = rready_reg;
  assign st_taken = st_taken_reg;
  assign wvalid = wvalid_reg;
  assign wdata = wdata_reg;
  assign wstrb = wstrb_reg;
  assign wchan = wchan_reg;
  assign used = used_reg;
endmodule : scb_buffer
`default_nettype wire

/* verilog/scb_params.svh */
// Constants of the shared channel data buffer: widths, depths and counts.
// Assumes it is included by bare name from the package and scb_buffer.
`ifndef SCB_PARAMS_SVH
`define SCB_PARAMS_SVH
`define SCB_DATA_W 64
`define SCB_CHANNELS 8
`define SCB_POOL_DEPTH 16
`define SCB_INFIFO_DEPTH 4
`define SCB_CHAN_W 3
`endif

/* verilog/scb_pkg.sv */
// Types shared by the buffer modules.
// Assumes scb_params.svh is on the include path.
`include "scb_params.svh"
package scb_pkg;
  typedef logic [`SCB_CHAN_W-1:0] scb_chan_t; // Channel number
endpackage : scb_pkg

/* verilog/scb_entry_if.sv */
// Valid/ready carrier for packed buffer entries between the buffer modules.
// Assumes one producer and one consumer on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface scb_entry_if #(parameter int W = 8);
  logic valid; // Entry offered
  logic ready; // Entry taken
  logic [W-1:0] data; // Entry payload
  modport prod (output valid, output data, input ready);
  modport cons (input valid, input data, output ready);
endinterface : scb_entry_if
`default_nettype wire

/* verilog/scb_fifo.sv */
// Small valid/ready FIFO sitting between the packer and the shared pool.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module scb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  scb_entry_if.cons in_if,
  scb_entry_if.prod out_if,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_ptr_reg; // Write index
  logic [AW-1:0] rd_ptr_reg; // Read index
  logic [$clog2(DEPTH+1)-1:0] cnt_reg; // Occupancy
  logic push; // Word accepted
  logic pop; // Word delivered

  // Honest full and empty
  assign in_if.ready = (cnt_reg != ($clog2(DEPTH+1))'(DEPTH));
  assign out_if.valid = (cnt_reg != '0);
  assign out_if.data = mem[rd_ptr_reg];
  assign push = in_if.valid && in_if.ready;
  assign pop = out_if.valid && out_if.ready;
  assign count = cnt_reg;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_if.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : scb_fifo
`default_nettype wire

/* verification/scb_buffer_asserts.sv */
// Port checker for the shared channel buffer.
// Assumes it is bound into scb_buffer and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module scb_buffer_asserts #(
  parameter int DATA_W = 64,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rready,
  input wire logic st_taken,
  input wire logic wvalid,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  input wire scb_pkg::scb_chan_t wchan,
  input wire logic wready,
  input wire logic [$clog2(DEPTH+1)-1:0] used
);
  import scb_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Write beat offered but stalled
  sequence w_stall;
    wvalid && !wready;
  endsequence
  // Write beat unchanged
  sequence w_kept;
    wvalid && $stable(wdata) && $stable(wstrb) && $stable(wchan);
  endsequence
  w_hold_a: assert property (w_stall |=> w_kept) else $error("write beat changed under stall");
  pool_bound_a: assert property (used <= DEPTH) else $error("pool holds more than its depth");
  used_step_a: assert property (used == $past(used) || used == $past(used) + 1'b1 || used + 1'b1 == $past(used))
    else $error("pool count jumped");
  take_shows_a: assert property (st_taken |-> wvalid) else $error("store pulse without write beat");
  one_write_a: assert property ($rose(wvalid) |-> st_taken) else $error("write beat without store");
  idle_pop_a: assert property (used == 0 |=> !st_taken) else $error("store taken from empty pool");
  strb_live_a: assert property (wvalid |-> wstrb != '0) else $error("write beat with no lanes");
  drain_once_a: assert property (wvalid && wready |=> !wvalid || st_taken) else $error("entry written twice");
  rready_wake_a: assert property ($fell(rst) |-> ##[0:2] rready) else $error("read side never ready");
endmodule : scb_buffer_asserts
bind scb_buffer scb_buffer_asserts #(.DATA_W(DATA_W), .DEPTH(DEPTH)) chk_u (.clk(clk), .rst(rst),
  .rready(rready), .st_taken(st_taken), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb), .wchan(wchan),
  .wready(wready), .used(used));
`default_nettype wire

/* verification/scb_axi_slave.sv */
// Behavioural interconnect slave: read beats for one load, write acceptance.
// Assumes go pulses one cycle after the load descriptor.
`timescale 1ns/100ps
`default_nettype none
module scb_axi_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire scb_pkg::scb_chan_t id,
  input wire logic [3:0] nbeats,
  input wire logic [7:0] tag,
  input wire logic slow,
  input wire logic rready,
  output logic rvalid,
  output logic [63:0] rdata,
  output scb_pkg::scb_chan_t rid,
  output logic rlast,
  output logic wready,
  output logic busy
);
  import scb_pkg::*;
  logic [3:0] left_reg; // Beats still to send
  logic [3:0] idx_reg; // Beat number
  logic [7:0] tag_reg; // Pattern seed
  logic [2:0] stall_reg; // Stall pattern
  // Byte l of beat n is tag plus 8n plus l
  function automatic logic [63:0] beat(input logic [7:0] t, input logic [3:0] n);
    for (int l = 0; l < 8; l++) beat[8*l+:8] = t + 8'(n * 8 + l);
  endfunction : beat
  // Offer a beat, hold it until taken, then show inverted data
  always_ff @(posedge clk) begin
    stall_reg <= rst ? 3'h1 : {stall_reg[1:0], stall_reg[2] ^ stall_reg[1]};
    if (rst) begin
      rvalid <= 1'b0;
      left_reg <= 4'h0;
      idx_reg <= 4'h0;
      tag_reg <= 8'h00;
      rid <= '0;
      rlast <= 1'b0;
      rdata <= 64'h0;
    end else if (go) begin
      left_reg <= nbeats;
      idx_reg <= 4'h0;
      tag_reg <= tag;
      rid <= id;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      rlast <= 1'b0;
      rdata <= ~rdata;
      left_reg <= left_reg - 4'h1;
      idx_reg <= idx_reg + 4'h1;
    end else if (!rvalid && left_reg != 4'h0 && !(slow && stall_reg[0])) begin
      rvalid <= 1'b1;
      rdata <= beat(tag_reg, idx_reg);
      rlast <= (left_reg == 4'h1);
    end
  end
  assign wready = !(slow && stall_reg[1]);
  assign busy = rvalid || left_reg != 4'h0;
endmodule : scb_axi_slave
`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench for the shared channel buffer.
// Assumes the slave model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ld_start = 1'b0, ld_src_inc = 1'b1, ld_dst_inc = 1'b1, ld_flush = 1'b1;
  scb_chan_t ld_chan = '0, st_chan = '0, s_id = '0, rid, wchan;
  logic [2:0] ld_src_off = 3'h0, ld_dst_off = 3'h0;
  logic [3:0] ld_src_size = 4'h8, s_nb = 4'h0;
  logic [7:0] s_tag = 8'h00, wstrb;
  logic rvalid, rlast, rready, st_taken, wvalid, wready, busy, st_req = 1'b0, go = 1'b0, slow = 1'b0;
  logic [63:0] rdata, wdata;
  logic [4:0] used;
  logic [71:0] expq [8][$]; // Expected strobe and data per channel
  logic [71:0] carry [8]; // Partial entry carried between loads
  int carry_lp [8]; // Next lane of that entry
  logic [31:0] rnd = 32'h9C69;
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #10 clk = ~clk;
  scb_buffer dut_u (.clk(clk), .rst(rst), .ld_start(ld_start), .ld_chan(ld_chan), .ld_src_off(ld_src_off),
    .ld_src_size(ld_src_size), .ld_src_inc(ld_src_inc), .ld_dst_off(ld_dst_off), .ld_dst_inc(ld_dst_inc),
    .ld_flush(ld_flush), .rvalid(rvalid), .rdata(rdata), .rid(rid), .rlast(rlast), .rready(rready),
    .st_req(st_req), .st_chan(st_chan), .st_taken(st_taken), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb),
    .wchan(wchan), .wready(wready), .used(used));
  scb_axi_slave slave_u (.clk(clk), .rst(rst), .go(go), .id(s_id), .nbeats(s_nb), .tag(s_tag), .slow(slow),
    .rready(rready), .rvalid(rvalid), .rdata(rdata), .rid(rid), .rlast(rlast), .wready(wready), .busy(busy));
  // Shift register random source
  function automatic logic [31:0] rand32();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction : rand32
  // Expected source byte
  function automatic logic [7:0] pat(input logic [7:0] tg, input int k, input int l);
    return tg + 8'(k * 8 + l);
  endfunction : pat
  // Byte mask from strobes
  function automatic logic [63:0] mask(input logic [7:0] s);
    for (int l = 0; l < 8; l++) mask[8*l+:8] = {8{s[l]}};
  endfunction : mask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Build expected entries, then issue the load and its beats
  task automatic load(input int ch, input int sz, input int so, input int dof, input logic di, input int nb,
    input logic fl = 1'b1, input logic si = 1'b1);
    logic [63:0] d;
    logic [7:0] s;
    logic [7:0] tg;
    int lp;
    tg = 8'(rand32());
    // A kept partial entry goes on filling from where it stopped
    {s, d} = carry[ch];
    lp = (s != 8'h00) ? carry_lp[ch] : dof;
    for (int k = 0; k < nb; k++) begin
      for (int i = 0; i < sz; i++) begin
        if (!di) lp = dof + i;
        d[8*lp+:8] = pat(tg, k, (so + (si ? k * sz : 0) + i) % 8);
        s[lp] = 1'b1;
        lp++;
        if (di ? lp == 8 : i == sz - 1) begin
          expq[ch].push_back({s, d});
          d = '0;
          s = '0;
          lp = 0;
        end
      end
    end
    if (s != 8'h00 && fl) expq[ch].push_back({s, d});
    carry[ch] = fl ? 72'h0 : {s, d};
    carry_lp[ch] = lp;
    @(posedge clk);
    ld_start <= 1'b1;
    ld_chan <= 3'(ch);
    ld_src_size <= 4'(sz);
    ld_src_off <= 3'(so);
    ld_dst_off <= 3'(dof);
    ld_dst_inc <= di;
    ld_src_inc <= si;
    ld_flush <= fl;
    @(posedge clk);
    ld_start <= 1'b0;
    go <= 1'b1;
    s_id <= 3'(ch);
    s_nb <= 4'(nb);
    s_tag <= tg;
    @(posedge clk);
    go <= 1'b0;
    // Slave takes the burst at this edge; look at busy once it is settled
    @(negedge clk);
    for (int t = 0; t < 3000 && busy; t++) @(negedge clk);
  endtask : load
  // Request stores until every expected entry was written
  task automatic drain(input int ch);
    @(posedge clk);
    st_req <= 1'b1;
    st_chan <= 3'(ch);
    for (int t = 0; t < 3000 && expq[ch].size() != 0; t++) @(negedge clk);
    @(posedge clk);
    st_req <= 1'b0;
    chk(64'(expq[ch].size()), 64'h0);
  endtask : drain
  // Compare every written entry with its channel queue
  always @(posedge clk) begin
    if (!rst && wvalid && wready) begin
      chk(64'(expq[wchan].size() != 0), 64'h1);
      if (expq[wchan].size() != 0) begin
        chk({56'h0, wstrb}, {56'h0, expq[wchan][0][71:64]});
        chk(wdata & mask(wstrb), expq[wchan][0][63:0]);
        void'(expq[wchan].pop_front());
      end
    end
  end
  // Hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    int sz, so, dof, ch;
    logic di, si;
    for (int c = 0; c < 8; c++) carry[c] = 72'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({61'h0, rready, wvalid, st_taken}, 64'h0);
    chk(64'(used), 64'h0);
    @(posedge clk);
    rst <= 1'b0;
    load(0, 8, 0, 0, 1, 4);
    drain(0);
    load(1, 8, 0, 2, 1, 2);
    drain(1);
    load(2, 4, 0, 0, 1, 2);
    repeat (4) @(negedge clk);
    chk(64'(used), 64'h1);
    drain(2);
    load(3, 4, 0, 4, 0, 2);
    drain(3);
    load(4, 2, 2, 5, 1, 3);
    load(5, 8, 0, 3, 1, 3);
    drain(5);
    drain(4);
    load(6, 4, 0, 2, 1, 1, 1'b0);
    load(6, 2, 2, 0, 1, 3);
    drain(6);
    load(1, 2, 4, 0, 1, 4, 1'b1, 1'b0);
    drain(1);
    $display("test fixed patterns done");
    @(posedge clk);
    st_req <= 1'b1;
    st_chan <= 3'h6;
    for (int t = 0; t < 6; t++) begin
      @(negedge clk);
      chk(64'(st_taken), 64'h0);
    end
    @(posedge clk);
    st_req <= 1'b0;
    $display("test empty store done");
    load(7, 8, 0, 0, 1, 12);
    fork
      load(7, 8, 0, 0, 1, 12);
      begin
        for (int t = 0; t < 500 && used != 5'h10; t++) @(negedge clk);
        repeat (8) @(negedge clk);
        chk(64'(used), 64'h10);
        chk(64'(rready), 64'h0);
        drain(7);
      end
    join
    $display("test pool full done");
    for (int n = 0; n < 16; n++) begin
      ch = int'(rand32() % 8);
      sz = 1 << (rand32() % 4);
      di = rand32() % 2;
      so = int'(rand32() % 8) & ~(sz - 1);
      dof = di ? int'(rand32() % 8) : int'(rand32() % 8) & ~(sz - 1);
      si = rand32() % 2;
      @(posedge clk);
      slow <= rand32() % 2;
      load(ch, sz, so, dof, di, 1 + int'(rand32() % 4), 1'b1, si);
      drain(ch);
    end
    $display("test random loads done");
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
